//--- pkg/channel_access_pkg.sv
// constants, types and address decoding for the channel access selection block
package channel_access_pkg;
  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;
  localparam int CHAN_W = 3;
  localparam int OFS_W = 4;

  localparam logic [6:0] CHAN_SEL_OFS = 7'h64;
  localparam logic [6:0] SVC_CHAN1_OFS = 7'h41;
  localparam logic [6:0] SVC_CHAN3_OFS = 7'h43;
  localparam logic [6:0] RX_DATA_PTR_OFS = 7'h78;
  localparam logic [6:0] RX_STAT_PTR_OFS = 7'h7a;
  localparam logic [6:0] TX_DATA_PTR_OFS = 7'h7b;
  localparam logic [6:0] CHAN_REGION_LAST = 7'h0f;

  localparam int CHAN_LSB = 0;
  localparam int A7_BIT = 3;
  localparam int SVC_MASK_LSB = 2;
  localparam int SVC_FIRST = 1;
  localparam int SVC_LAST = 3;

  localparam logic [3:0] CHAN_SEL_RESET = 4'h0;
  localparam logic [7:0] SVC_RESET = 8'h00;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ISSUE = 2'b01,
    ST_REPLY = 2'b11
  } state_type;

  typedef enum logic [2:0] {
    ACC_NONE = 3'h0,
    ACC_CHAN = 3'h1,
    ACC_CSEL = 3'h2,
    ACC_SVC = 3'h3,
    ACC_RXD = 3'h4,
    ACC_RXS = 3'h5,
    ACC_TXD = 3'h6
  } access_type;

  function automatic access_type decode_access(input logic [6:0] addr);
    if (addr <= CHAN_REGION_LAST) begin
      return ACC_CHAN;
    end else if (addr == CHAN_SEL_OFS) begin
      return ACC_CSEL;
    end else if (addr >= SVC_CHAN1_OFS && addr <= SVC_CHAN3_OFS) begin
      return ACC_SVC;
    end else if (addr == RX_DATA_PTR_OFS) begin
      return ACC_RXD;
    end else if (addr == RX_STAT_PTR_OFS) begin
      return ACC_RXS;
    end else if (addr == TX_DATA_PTR_OFS) begin
      return ACC_TXD;
    end else begin
      return ACC_NONE;
    end
  endfunction
endpackage

//--- design/svc_channel_regs.sv
// the three global service channel registers with channel number masked in on read
module svc_channel_regs (
  input wire logic mclk,
  input wire logic rstSync,
  input wire logic clkEn,
  input wire logic wrEn,
  input wire logic [1:0] wrIdx,
  input wire logic [7:0] wData,
  input wire logic [1:0] rdIdx,
  input wire logic [2:0] maskChan,
  output logic [7:0] rData
);
  logic [7:0] svcReg [channel_access_pkg::SVC_FIRST:channel_access_pkg::SVC_LAST];

  genvar i;
  generate
    for (i = channel_access_pkg::SVC_FIRST; i <= channel_access_pkg::SVC_LAST; i++) begin : g_svc
      always_ff @(posedge mclk or negedge rstSync) begin
        if (!rstSync) begin
          svcReg[i] <= channel_access_pkg::SVC_RESET;
        end else if (clkEn && wrEn && wrIdx == 2'(i)) begin
          svcReg[i] <= wData;
        end
      end
    end
  endgenerate

  // stored bits are untouched; only the returned copy carries the channel
  always_comb begin
    rData = 8'h00;
    if (rdIdx != 2'h0) begin
      rData = svcReg[rdIdx];
    end
    rData[channel_access_pkg::SVC_MASK_LSB +: channel_access_pkg::CHAN_W] = maskChan;
  end
endmodule

//--- design/channel_access_select.sv
// channel select register, context selection and indirect pointer routing
module channel_access_select (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic clkEn,
  input wire logic busReq,
  input wire logic busWrite,
  input wire logic [6:0] busAddr,
  input wire logic [7:0] busWData,
  input wire logic srvActive,
  input wire logic [2:0] srvChannel,
  input wire logic [7:0] intRData,
  input wire logic [7:0] fifoRData,
  output logic busAck,
  output logic [7:0] busRData,
  output logic [7:0] intAddr,
  output logic intRd,
  output logic intWr,
  output logic [7:0] intWData,
  output logic fifoPop,
  output logic fifoPush,
  output logic fifoStatus,
  output logic [2:0] fifoChan,
  output logic [7:0] fifoWData,
  output logic [2:0] activeChan
);
  logic [1:0] rstPipe;
  logic rstSync;
  channel_access_pkg::state_type stateReg;
  channel_access_pkg::access_type reqKind;
  channel_access_pkg::access_type kindReg;
  logic [3:0] chanSel_reg;
  logic [2:0] ctxNext;
  logic [2:0] ctxReg;
  logic wrReg;
  logic srvReg;
  logic [1:0] idxReg;
  logic take;
  logic [7:0] svcRData;
  logic [7:0] rData_next;

  // reset enters asynchronously but is released through two flops
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rstPipe <= 2'h0;
    end else if (clkEn) begin
      rstPipe <= {rstPipe[0], 1'b1};
    end
  end
  assign rstSync = rstPipe[1];

  assign reqKind = channel_access_pkg::decode_access(busAddr);
  assign take = clkEn && busReq && stateReg == channel_access_pkg::ST_IDLE;

  assign ctxNext = srvActive ? srvChannel : chanSel_reg[2:0];

  always_ff @(posedge mclk or negedge rstSync) begin
    if (!rstSync) begin
      stateReg <= channel_access_pkg::ST_IDLE;
    end else if (clkEn) begin
      case (stateReg)
        channel_access_pkg::ST_IDLE: begin
          if (busReq) begin
            stateReg <= channel_access_pkg::ST_ISSUE;
          end
        end
        channel_access_pkg::ST_ISSUE: begin
          stateReg <= channel_access_pkg::ST_REPLY;
        end
        default: begin
          stateReg <= channel_access_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // request details held until the answer, so the context cannot shift mid-access
  always_ff @(posedge mclk or negedge rstSync) begin
    if (!rstSync) begin
      kindReg <= channel_access_pkg::ACC_NONE;
      ctxReg <= 3'h0;
      wrReg <= 1'b0;
      srvReg <= 1'b0;
      idxReg <= 2'h0;
    end else if (take) begin
      kindReg <= reqKind;
      ctxReg <= ctxNext;
      wrReg <= busWrite;
      srvReg <= srvActive;
      idxReg <= busAddr[1:0];
    end
  end

  always_ff @(posedge mclk or negedge rstSync) begin
    if (!rstSync) begin
      chanSel_reg <= channel_access_pkg::CHAN_SEL_RESET;
    end else if (take && busWrite && reqKind == channel_access_pkg::ACC_CSEL) begin
      chanSel_reg <= busWData[3:0];
    end
  end

  // internal channel register strobes
  always_ff @(posedge mclk or negedge rstSync) begin
    if (!rstSync) begin
      intAddr <= 8'h00;
      intRd <= 1'b0;
      intWr <= 1'b0;
      intWData <= 8'h00;
    end else if (clkEn) begin
      intRd <= take && !busWrite && reqKind == channel_access_pkg::ACC_CHAN;
      intWr <= take && busWrite && reqKind == channel_access_pkg::ACC_CHAN;
      if (take) begin
        // select bit 3 as address msb
        intAddr <= {chanSel_reg[channel_access_pkg::A7_BIT], ctxNext, busAddr[3:0]};
        intWData <= busWData;
      end
    end
  end

  // pointers touch the FIFO only inside a service routine; elsewhere they do nothing
  always_ff @(posedge mclk or negedge rstSync) begin
    if (!rstSync) begin
      fifoPop <= 1'b0;
      fifoPush <= 1'b0;
      fifoStatus <= 1'b0;
      fifoChan <= 3'h0;
      fifoWData <= 8'h00;
    end else if (clkEn) begin
      fifoPop <= take && srvActive && !busWrite &&
                 (reqKind == channel_access_pkg::ACC_RXD || reqKind == channel_access_pkg::ACC_RXS);
      fifoPush <= take && srvActive && busWrite && reqKind == channel_access_pkg::ACC_TXD;
      if (take) begin
        fifoStatus <= reqKind == channel_access_pkg::ACC_RXS;
        fifoChan <= ctxNext;
        fifoWData <= busWData;
      end
    end
  end

  svc_channel_regs u_svc (
    .mclk(mclk),
    .rstSync(rstSync),
    .clkEn(clkEn),
    .wrEn(take && busWrite && reqKind == channel_access_pkg::ACC_SVC),
    .wrIdx(busAddr[1:0]),
    .wData(busWData),
    .rdIdx(idxReg),
    .maskChan(ctxReg),
    .rData(svcRData)
  );

  always_comb begin
    rData_next = 8'h00;
    case (kindReg)
      channel_access_pkg::ACC_CHAN: begin
        rData_next = intRData;
      end
      channel_access_pkg::ACC_CSEL: begin
        rData_next = {4'h0, chanSel_reg};
      end
      channel_access_pkg::ACC_SVC: begin
        rData_next = svcRData;
      end
      channel_access_pkg::ACC_RXD, channel_access_pkg::ACC_RXS: begin
        rData_next = srvReg ? fifoRData : 8'h00;
      end
      default: begin
        rData_next = 8'h00;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rstSync) begin
    if (!rstSync) begin
      busAck <= 1'b0;
      busRData <= 8'h00;
      activeChan <= 3'h0;
    end else if (clkEn) begin
      busAck <= stateReg == channel_access_pkg::ST_ISSUE;
      if (stateReg == channel_access_pkg::ST_ISSUE && !wrReg) begin
        busRData <= rData_next;
      end
      activeChan <= ctxNext;
    end
  end

  chk_ack_timing: assert property (@(posedge mclk iff clkEn) disable iff (!rstSync)
    take |=> ##1 busAck)
    else $error("answer not two cycles after request");

  chk_chan_route: assert property (@(posedge mclk iff clkEn) disable iff (!rstSync)
    take && !srvActive && reqKind == channel_access_pkg::ACC_CHAN
    |=> intAddr[6:4] == $past(chanSel_reg[2:0]))
    else $error("channel access missed selected channel");

  chk_srv_route: assert property (@(posedge mclk iff clkEn) disable iff (!rstSync)
    take && srvActive && reqKind == channel_access_pkg::ACC_CHAN
    |=> intAddr[6:4] == $past(srvChannel))
    else $error("service access missed requesting channel");

  chk_addr_msb: assert property (@(posedge mclk iff clkEn) disable iff (!rstSync)
    (intRd || intWr) |-> intAddr[7] == chanSel_reg[channel_access_pkg::A7_BIT])
    else $error("internal address msb differs from select bit 3");

  chk_cmd_route: assert property (@(posedge mclk iff clkEn) disable iff (!rstSync)
    take && busWrite && !srvActive && reqKind == channel_access_pkg::ACC_CHAN
    |=> intWr && intAddr[6:4] == $past(chanSel_reg[2:0]) ##1 !intWr)
    else $error("command not sent to selected channel");

  chk_pop_context: assert property (@(posedge mclk iff clkEn) disable iff (!rstSync)
    (fifoPop || fifoPush) |-> $past(srvActive) && fifoChan == $past(srvChannel))
    else $error("FIFO touched outside service context");

  chk_ptr_pop: assert property (@(posedge mclk iff clkEn) disable iff (!rstSync)
    take && srvActive && !busWrite && reqKind == channel_access_pkg::ACC_RXD
    |=> fifoPop && !fifoStatus ##1 !fifoPop)
    else $error("receive pointer read did not pop once");

  chk_svc_mask: assert property (@(posedge mclk iff clkEn) disable iff (!rstSync)
    take && !srvActive && !busWrite && reqKind == channel_access_pkg::ACC_SVC
    |=> ##1 busAck && busRData[4:2] == $past(chanSel_reg[2:0], 2))
    else $error("service channel read lacks select channel");
endmodule

//--- tb/chan_side_model.sv
// far-side model: channel register file and fifo heads
module chan_side_model (
  input wire logic [7:0] intAddr,
  input wire logic fifoStatus,
  input wire logic [2:0] fifoChan,
  output logic [7:0] intRData,
  output logic [7:0] fifoRData
);
  timeunit 1ns;
  timeprecision 1ps;
  // data follows the address, so a wrong channel or offset shows in the read value
  assign intRData = intAddr ^ 8'h3c;
  assign fifoRData = {4'ha, fifoStatus, fifoChan};
endmodule

//--- tb/channel_access_select_bench.sv
// self-checking bench for the channel access selection block
module channel_access_select_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, resetn, clkEn, busReq, busWrite, srvActive, busAck, intRd, intWr, fifoPop, fifoPush, fifoStatus, w, s;
  logic [6:0] busAddr;
  logic [7:0] busWData, intRData, fifoRData, busRData, intAddr, intWData, fifoWData, rd, sel, d;
  logic [2:0] srvChannel, fifoChan, activeChan, c, ch;
  logic [3:0] o;
  logic [8:0] side;
  int error_cnt, n_checks, seed, i;

  channel_access_select DUT (.mclk(mclk), .resetn(resetn), .clkEn(clkEn), .busReq(busReq), .busWrite(busWrite),
    .busAddr(busAddr), .busWData(busWData), .srvActive(srvActive), .srvChannel(srvChannel), .intRData(intRData),
    .fifoRData(fifoRData), .busAck(busAck), .busRData(busRData), .intAddr(intAddr), .intRd(intRd), .intWr(intWr),
    .intWData(intWData), .fifoPop(fifoPop), .fifoPush(fifoPush), .fifoStatus(fifoStatus), .fifoChan(fifoChan),
    .fifoWData(fifoWData), .activeChan(activeChan));
  chan_side_model farSide (.intAddr(intAddr), .fifoStatus(fifoStatus), .fifoChan(fifoChan),
    .intRData(intRData), .fifoRData(fifoRData));

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // request held one cycle past the answer edge; strobes seen one cycle after the take
  task automatic acc(input logic wr, input logic [6:0] a, input logic [7:0] dat, input logic sv, input logic [2:0] ct);
    @(negedge mclk);
    busReq = 1'b1;
    busWrite = wr;
    busAddr = a;
    busWData = dat;
    srvActive = sv;
    srvChannel = ct;
    @(posedge mclk);
    #1 side = {busAck, intRd, intWr, fifoPop, fifoPush, fifoStatus, fifoChan};
    @(posedge mclk);
    #1 chk(busAck, 1'b1);
    rd = busRData;
    @(posedge mclk);
    @(negedge mclk);
    busReq = 1'b0;
  endtask

  initial begin
    #(25 * 5000);
    error_cnt++;
    close_out();
  end

  initial begin
    seed = 31;
    resetn = 1'b0;
    clkEn = 1'b1;
    {busReq, busWrite, srvActive, busAddr, busWData, srvChannel} = '0;
    repeat (16) @(posedge mclk);
    @(negedge mclk);
    resetn = 1'b1;
    repeat (3) @(posedge mclk);
    acc(1'b0, channel_access_pkg::CHAN_SEL_OFS, 8'h00, 1'b0, 3'h0);
    chk(rd, 8'h00);
    $display("test reset value done");
    for (i = 0; i < 40; i++) begin
      sel = {4'h0, 4'($random(seed))};
      acc(1'b1, 7'h64, sel, 1'b0, 3'h0);
      acc(1'b0, 7'h64, 8'h00, 1'b1, 3'($random(seed)));
      chk(rd, sel);
      s = 1'($random(seed));
      c = 3'($random(seed));
      o = 4'($random(seed));
      w = 1'($random(seed));
      d = 8'($random(seed));
      acc(w, {3'h0, o}, d, s, c);
      ch = s ? c : sel[2:0];
      chk(intAddr, {sel[3], ch, o});
      chk(side[8:4], {2'b00, w, 2'b00} | {1'b0, !w, 3'b000});
      chk(activeChan, ch);
      if (w) begin
        chk(intWData, d);
      end else begin
        chk(rd, {sel[3], ch, o} ^ 8'h3c);
      end
    end
    $display("test channel routing done");
    for (i = 0; i < 3; i++) begin
      d = 8'($random(seed));
      acc(1'b1, 7'h41 + 7'(i), d, 1'b0, 3'h0);
      acc(1'b0, 7'h41 + 7'(i), 8'h00, 1'b0, 3'h0);
      chk(rd, {d[7:5], sel[2:0], d[1:0]});
      acc(1'b0, 7'h41 + 7'(i), 8'h00, 1'b1, 3'(i + 4));
      chk(rd, {d[7:5], 3'(i + 4), d[1:0]});
    end
    $display("test service channel done");
    c = 3'h5;
    acc(1'b0, 7'h78, 8'h00, 1'b1, c);
    chk(side, {6'b000100, c});
    chk(rd, {4'ha, 1'b0, c});
    acc(1'b0, 7'h7a, 8'h00, 1'b1, c);
    chk(side, {6'b000101, c});
    chk(rd, {4'ha, 1'b1, c});
    acc(1'b1, 7'h7b, 8'h96, 1'b1, 3'h2);
    chk({side[8:4], side[2:0], fifoWData}, {5'b00001, 3'h2, 8'h96});
    acc(1'b0, 7'h78, 8'h00, 1'b0, 3'h0);
    chk({side[8:4], rd}, 13'h0000);
    $display("test pointer access done");
    acc(1'b1, 7'h50, 8'hff, 1'b0, 3'h0);
    chk(side[8:4], 5'h00);
    acc(1'b0, 7'h50, 8'h00, 1'b0, 3'h0);
    chk(rd, 8'h00);
    $display("test unmapped done");
    // clock enable low must hold the context even though the service inputs move
    ch = ~sel[2:0];
    @(negedge mclk);
    clkEn = 1'b0;
    srvActive = 1'b1;
    srvChannel = ch;
    repeat (4) @(posedge mclk);
    #1 chk(activeChan, sel[2:0]);
    @(negedge mclk);
    clkEn = 1'b1;
    @(posedge mclk);
    #1 chk(activeChan, ch);
    $display("test clock enable done");
    close_out();
  end
endmodule
